// File: logic/adc_ctrl.v
// digital control and output port of a pipelined converter
// Notes on behaviour
// - calibration run lasts 4000 clock cycles
// - output enable low drives data pins
// - output enable high floats data pins
// - sleep request high holds power-down; entered only once a running calibration ends
// - resume within wake-up delay after sleep
// - pipeline contents corrupted across power-down
// - ready low while calibrating or sleeping
// - out-of-range flag for input outside span
// - result is 12-bit straight binary
// - calibration starts automatically at power-on
// - one result per clock, fixed latency; the output buffer drops words when full and inserts empty cycles
`include "adc_ctrl_defines.vh"
module adc_ctrl #(
	parameter data_width = `DATA_WIDTH,
	parameter cal_cycles = `CAL_RUN_CYCLES,
	parameter wake_cycles = `WAKE_UP_CYCLES
)(
	// clock and reset
	input wire clk_sys,
	input wire arst_n,
	// control levels from the host
	input wire cal_request,
	input wire output_enable_n,
	input wire sleep_request,
	// sample from the conversion core, with range flags
	input wire [data_width-1:0] signal_input,
	input wire below_ground,
	input wire above_reference,
	input wire sample_valid,
	output reg sample_ready,
	// receiver side of the output word path
	input wire out_ready,
	output reg out_valid,
	// data pins as three signals
	output reg [data_width-1:0] data_out,
	output reg data_oe,
	output reg out_of_range,
	output reg ready
);
	reg rst_meta;
	reg rst_sync;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [11:0] cal_count;
	reg [7:0] wake_count;
	reg [1:0] req_count;
	reg [`DATA_WIDTH:0] pipe [0:`PIPE_LATENCY-1];
	reg [`DATA_WIDTH:0] buf_word [0:1];
	reg [1:0] buf_count;
	reg buf_rd;
	reg buf_wr;
	wire req_met;
	wire pipe_tail_ok;
	wire push;
	wire pop;
	integer i;

	// reset release through two flops so removal is clean
	// only the second flop feeds the logic; the first may be metastable
	always @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end

	// count consecutive high cycles of the calibrate request
	always @(posedge clk_sys or negedge rst_sync)
		if (!rst_sync)
			req_count <= 2'h0;
		else if (!cal_request)
			req_count <= 2'h0;
		else if (req_count != `CAL_REQ_MIN_CYCLES)
			req_count <= req_count + 2'h1;
	// a short request pulse is ignored, not queued
	assign req_met = cal_request && (req_count == `CAL_REQ_MIN_CYCLES - 2'h1);

	// mode selection: calibration, run, sleep, wake
	always @*
	begin
		next_state = state;
		case (state)
			`ST_CAL:
				if (cal_count == cal_cycles - 12'h1)
					next_state = sleep_request ? `ST_SLEEP : `ST_RUN;
			`ST_RUN:
				if (sleep_request)
					next_state = `ST_SLEEP;
				else if (req_met)
					next_state = `ST_CAL;
			`ST_SLEEP:
				if (!sleep_request)
					next_state = `ST_WAKE;
			`ST_WAKE:
				if (sleep_request)
					next_state = `ST_SLEEP;
				else if (wake_count == wake_cycles - 8'h1)
					next_state = `ST_RUN;
			default:
				next_state = `ST_CAL;
		endcase
		// a full request restarts calibration while calibrating or waking;
		// asleep it is dropped, and sleep keeps priority over waking
		if (req_met && (state == `ST_CAL
			|| (state == `ST_WAKE && !sleep_request)))
			next_state = `ST_CAL;
	end

	// state and the cycle counters; reset lands in calibration
	always @(posedge clk_sys or negedge rst_sync)
		if (!rst_sync)
		begin
			state <= `ST_CAL;
			cal_count <= 12'h0;
			wake_count <= 8'h0;
		end
		else
		begin
			state <= next_state;
			// a fresh request mid-run clears the count, so it restarts
			if (state == `ST_CAL && next_state == `ST_CAL && !req_met)
				cal_count <= cal_count + 12'h1;
			else
				cal_count <= 12'h0;
			// leaving wake early, back to sleep, starts the delay over
			if (state == `ST_WAKE && next_state == `ST_WAKE)
				wake_count <= wake_count + 8'h1;
			else
				wake_count <= 8'h0;
		end

	// fixed latency pipeline; flushed in power-down so stale words die
	always @(posedge clk_sys or negedge rst_sync)
		if (!rst_sync)
		begin
			for (i = 0; i < `PIPE_LATENCY; i = i + 1)
				pipe[i] <= {(`DATA_WIDTH+1){1'b0}};
		end
		else
		begin
			// the range flag rides as the top bit of every stage
			pipe[0] <= (state == `ST_SLEEP) ? {(`DATA_WIDTH+1){1'b0}}
				: {below_ground | above_reference, signal_input};
			for (i = 1; i < `PIPE_LATENCY; i = i + 1)
				pipe[i] <= (state == `ST_SLEEP) ? {(`DATA_WIDTH+1){1'b0}}
					: pipe[i-1];
		end

	// the core accepts a new sample every clock while no sleep is requested
	always @(posedge clk_sys or negedge rst_sync)
		if (!rst_sync)
			sample_ready <= 1'b0;
		else
			// conversion stops at once on sleep, even mid-calibration
			sample_ready <= !sleep_request
				&& (next_state != `ST_SLEEP);

	// pipeline tail enters the buffer only while converting
	assign pipe_tail_ok = sample_valid && state != `ST_SLEEP;
	assign push = pipe_tail_ok && buf_count != 2'h2;
	assign pop = out_valid && out_ready;

	// two-entry buffer so a receiver stall loses no word until both entries fill
	// the core cannot be held, so a word meeting a full buffer is dropped
	always @(posedge clk_sys or negedge rst_sync)
		if (!rst_sync)
		begin
			buf_count <= 2'h0;
			buf_rd <= 1'b0;
			buf_wr <= 1'b0;
			buf_word[0] <= {(`DATA_WIDTH+1){1'b0}};
			buf_word[1] <= {(`DATA_WIDTH+1){1'b0}};
		end
		else
		begin
			if (push)
			begin
				buf_word[buf_wr] <= pipe[`PIPE_LATENCY-1];
				buf_wr <= ~buf_wr;
			end
			if (pop)
				buf_rd <= ~buf_rd;
			buf_count <= buf_count + {1'b0, push} - {1'b0, pop};
		end

	// output registers; the word is straight binary, no offset coding
	always @(posedge clk_sys or negedge rst_sync)
		if (!rst_sync)
		begin
			out_valid <= 1'b0;
			data_out <= {data_width{1'b0}};
			out_of_range <= 1'b0;
			data_oe <= 1'b0;
			ready <= 1'b0;
		end
		else
		begin
			data_oe <= ~output_enable_n;
			ready <= (next_state == `ST_RUN);
			// output mirrors the buffer head; a pop shows the next
			// pop and push on one entry cost one empty cycle
			if (!out_valid || out_ready)
			begin
				out_valid <= (buf_count != 2'h0) && !(pop && buf_count == 2'h1);
				data_out <= buf_word[pop ? ~buf_rd : buf_rd][data_width-1:0];
				out_of_range <= buf_word[pop ? ~buf_rd : buf_rd][`DATA_WIDTH];
			end
		end
endmodule // adc_ctrl

// File: logic/adc_ctrl_defines.vh
// constants for the converter control port
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define CAL_REQ_MIN_CYCLES 2'h3
`define CAL_RUN_CYCLES 12'hfa0
`define WAKE_UP_CYCLES 8'h10
`define PIPE_LATENCY 4'h6
`define DATA_WIDTH 12
`define ST_CAL 2'h0
`define ST_RUN 2'h1
`define ST_SLEEP 2'h2
`define ST_WAKE 2'h3
`endif

// File: tb/adc_ctrl_props.sv
// assertion checker for the converter control port
module adc_ctrl_props (
	// watched ports
	input wire clk_sys,
	input wire arst_n,
	input wire cal_request,
	input wire output_enable_n,
	input wire sleep_request,
	input wire out_ready,
	input wire out_valid,
	input wire [11:0] data_out,
	input wire out_of_range,
	input wire data_oe,
	input wire sample_ready,
	input wire ready
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [2:0] up;
	// wait out the design's own reset synchroniser
	always @(posedge clk_sys or negedge arst_n)
		if (!arst_n)
			up <= 3'h0;
		else
			up <= {up[1:0], 1'b1};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!up[2]);
	AST_OE_ON: assert property (!output_enable_n |=> data_oe)
		else $error("pins not driven");
	AST_OE_OFF: assert property (output_enable_n |=> !data_oe)
		else $error("pins not floated");
	AST_SLEEP: assert property (sleep_request |=> !ready && !sample_ready)
		else $error("awake in sleep");
	AST_CAL_RDY: assert property (cal_request[*3] |-> ##[1:2] !ready)
		else $error("ready during cal");
	AST_RDY_RISE: assert property ($rose(ready) |-> !$past(sleep_request))
		else $error("ready rose asleep");
	AST_CAL_LEN: assert property ($fell(ready) && !$past(sleep_request) |-> !ready[*8])
		else $error("cal too short");
	AST_RDY_HOLD: assert property (ready && !sleep_request && !cal_request |=> ready)
		else $error("ready dropped");
	AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(data_out) && $stable(out_of_range))
		else $error("word lost in stall");
endmodule // adc_ctrl_props
bind adc_ctrl adc_ctrl_props u_adc_ctrl_props (.clk_sys, .arst_n, .cal_request, .output_enable_n, .sleep_request, .out_ready, .out_valid, .data_out, .out_of_range, .data_oe, .sample_ready, .ready);

// File: tb/adc_host.sv
// host that stalls and keeps only words taken while ready
module adc_host (
	// from the converter
	input wire logic clk_sys,
	input wire logic ready,
	input wire logic out_valid,
	input wire logic data_oe,
	input wire logic [11:0] data_out,
	input wire logic out_of_range,
	// to the converter and the bench
	output logic out_ready = 0,
	output logic [11:0] cap = 12'h000,
	output logic cap_or = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	// accept every other edge so the buffer fills and refuses
	always @(posedge clk_sys)
	begin
		out_ready <= #1 ~out_ready;
		if (out_valid && out_ready && ready && data_oe)
		begin
			cap <= data_out;
			cap_or <= out_of_range;
		end
	end
endmodule // adc_host

// File: tb/test_adc_ctrl.sv
// self-checking bench for the converter control port
module test_adc_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, arst_n = 0, cal_request = 0, output_enable_n = 1;
	logic sleep_request = 0, below_ground = 0, above_reference = 0;
	logic sample_valid = 0;
	logic [11:0] signal_input = 12'h000;
	wire sample_ready, out_ready, out_valid, data_oe, out_of_range, ready;
	wire [11:0] data_out, cap;
	wire cap_or;
	int fail_count = 0, checks_done = 0, n;
	initial forever #4 clk_sys = ~clk_sys;
	adc_ctrl #(.cal_cycles(20), .wake_cycles(4)) u_adc_ctrl (.clk_sys, .arst_n, .cal_request, .output_enable_n, .sleep_request, .signal_input, .below_ground, .above_reference, .sample_valid, .sample_ready, .out_ready, .out_valid, .data_out, .data_oe, .out_of_range, .ready);
	adc_host u_adc_host (.clk_sys, .ready, .out_valid, .data_oe, .data_out, .out_of_range, .out_ready, .cap, .cap_or);
	task chk(input logic [11:0] g, e);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chb(input logic g, e);
		chk({11'h0, g}, {11'h0, e});
	endtask
	task stop_test;
		$display("fails %0d checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// step k edges, landing just after the last one
	task cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task wait_rdy(input int lim);
		n = 0;
		while (ready !== 1'b1 && n < lim)
		begin
			cyc(1);
			n++;
		end
	endtask
	task t_word(input logic [11:0] v, input logic b, a);
		signal_input = v;
		below_ground = b;
		above_reference = a;
		cyc(20);
		chk(cap, v);
		chb(cap_or, b | a);
	endtask
	task t_cal(input int len);
		cal_request = 1;
		cyc(len);
		cal_request = 0;
		cyc(3);
		chb(ready, len < 3);
		cyc(12);
		chb(ready, len < 3);
		wait_rdy(15);
		chb(ready, 1);
	endtask
	// mid-run reset, power-on calibration, then a fresh request
	task t_reset;
		arst_n = 0;
		cyc(2);
		chb(ready, 0);
		arst_n = 1;
		cyc(12);
		chb(ready, 0);
		wait_rdy(20);
		chb(ready, 1);
		t_cal(3);
	endtask
	initial
	begin
		cyc(8);
		arst_n = 1;
		cyc(18);
		chb(ready, 0);
		wait_rdy(10);
		chb(ready, 1);
		output_enable_n = 0;
		cyc(2);
		chb(data_oe, 1);
		output_enable_n = 1;
		cyc(2);
		chb(data_oe, 0);
		output_enable_n = 0;
		sample_valid = 1;
		t_word(12'h5a3, 0, 1);
		t_word(12'hfff, 1, 0);
		t_word(12'h000, 0, 0);
		t_cal(2);
		t_cal(3);
		sleep_request = 1;
		cyc(2);
		chb(ready, 0);
		chb(sample_ready, 0);
		cyc(5);
		sleep_request = 0;
		wait_rdy(12);
		chb(ready, 1);
		t_cal(3);
		t_reset();
		stop_test();
	end
	// run needs about 220 cycles; the limit leaves ample margin
	initial
	begin
		#8000;
		fail_count++;
		stop_test();
	end
endmodule // test_adc_ctrl
